// ---- common/psb_defines.svh ----
`ifndef PSB_DEFINES_SVH
`define PSB_DEFINES_SVH
`define PSB_DATA_W      32
`define PSB_REG_W       5
`define PSB_ZERO_REG    5'h00
`define PSB_SLIP_ONE    1'h1
`endif

// ---- common/psb_pkg.sv ----
`include "psb_defines.svh"
package psb_pkg;
   typedef logic [`PSB_DATA_W-1:0] psb_data_t;
   typedef logic [`PSB_REG_W-1:0]  psb_reg_t;

   // Decoded instruction attributes for one stage
   typedef struct packed {
      logic     valid;      // Holds a live instruction
      logic     killed;     // Cancelled by likely-branch, return or exception
      psb_reg_t src_a;
      psb_reg_t src_b;
      logic     use_a;
      logic     use_b;
      psb_reg_t dest;
      logic     wr_dest;
      logic     is_load;    // Load or move-from product/coprocessor
      logic     is_store;
      logic     is_mem;     // Needs the data cache
      logic     is_mfprod;  // Move from product high/low
      logic     is_cop_cfg; // Write to coprocessor config/status
   } psb_instr_s;

   typedef enum logic [1:0] {
      PSB_SEL_RF = 2'h0,
      PSB_SEL_EX = 2'h1,
      PSB_SEL_DC = 2'h2,
      PSB_SEL_WB = 2'h3
   } psb_sel_e;

   typedef enum logic [1:0] {
      PSB_RUN      = 2'h0,
      PSB_SLIP_LD  = 2'h1,
      PSB_SLIP_MD  = 2'h2,
      PSB_SLIP_ONE = 2'h3
   } psb_state_e;

   typedef struct packed {
      psb_state_e state;
      logic       hold;
      logic       bubble;
      logic       ld_ilk;
      logic       md_ilk;
      logic       stld_ilk;
      logic       cpi;
      logic       store_busy;
      psb_sel_e   sel_a;
      psb_sel_e   sel_b;
      logic       dc_to_rf_a;
      logic       dc_to_rf_b;
      psb_reg_t   rf_ra;
      psb_reg_t   rf_rb;
      psb_reg_t   rf_wa;
      logic       rf_we;
   } psb_state_s;
endpackage

// ---- src/psb_pipeline_slip_bypass_control.sv ----
`timescale 1ns/1ps
`include "psb_defines.svh"
module psb_pipeline_slip_bypass_control (
   input  wire logic                  i_ref_clk,      // Core pipeline clock
   input  wire logic                  i_reset_n,      // Async reset, active low
   input  wire psb_pkg::psb_instr_s   i_rf_instr,     // Instruction in register fetch
   input  wire psb_pkg::psb_instr_s   i_ex_instr,     // Instruction in execute
   input  wire psb_pkg::psb_instr_s   i_dc_instr,     // Instruction in data cache stage
   input  wire psb_pkg::psb_instr_s   i_wb_instr,     // Instruction in writeback
   input  wire logic                  i_muldiv_busy,  // Multiply/divide running
   output logic                       o_fetch_hold,   // Hold fetch and register fetch
   output logic                       o_ex_bubble,    // Insert no-op into execute
   output logic                       o_ld_ilk,       // Load data interlock active
   output logic                       o_md_ilk,       // Muldiv busy interlock active
   output logic                       o_stld_ilk,     // Store-load interlock active
   output logic                       o_cpi,          // Coprocessor write interlock active
   output psb_pkg::psb_sel_e          o_ex_sel_a,     // Execute operand A source
   output psb_pkg::psb_sel_e          o_ex_sel_b,     // Execute operand B source
   output logic                       o_rf_dc_byp_a,  // Data cache result into reg fetch A
   output logic                       o_rf_dc_byp_b,  // Data cache result into reg fetch B
   output psb_pkg::psb_reg_t          o_rf_read_a,    // Register file read address A
   output psb_pkg::psb_reg_t          o_rf_read_b,    // Register file read address B
   output psb_pkg::psb_reg_t          o_rf_write_a,   // Register file write address
   output logic                       o_rf_write_en   // Register file write enable
);

   psb_pkg::psb_state_s st_reg;
   psb_pkg::psb_state_s st_next;

   // Does producer stage write a register that consumer reads
   function automatic logic hits(input psb_pkg::psb_instr_s prod, input psb_pkg::psb_reg_t src,
                                 input logic used);
      hits = used && prod.valid && !prod.killed && prod.wr_dest
             && (prod.dest == src) && (src != `PSB_ZERO_REG);
   endfunction

   // Forward select for an execute operand, nearest stage first
   function automatic psb_pkg::psb_sel_e pick(input psb_pkg::psb_instr_s ex,
                                              input psb_pkg::psb_instr_s dc,
                                              input psb_pkg::psb_instr_s wb,
                                              input psb_pkg::psb_reg_t src, input logic used);
      if (hits(ex, src, used)) begin
         pick = psb_pkg::PSB_SEL_EX;
      end else if (hits(dc, src, used)) begin
         pick = psb_pkg::PSB_SEL_DC;
      end else if (hits(wb, src, used)) begin
         pick = psb_pkg::PSB_SEL_WB;
      end else begin
         pick = psb_pkg::PSB_SEL_RF;
      end
   endfunction

   logic rf_live;
   logic ex_live;
   logic dep_ex;
   logic ld_ilk_c;
   logic md_ilk_c;
   logic stld_ilk_c;
   logic cpi_c;
   logic dcb_c;
   logic slip_c;

   always_comb begin
      st_next = st_reg;
      // Killed instructions raise no interlock
      rf_live = i_rf_instr.valid && !i_rf_instr.killed;
      ex_live = i_ex_instr.valid && !i_ex_instr.killed;
      dep_ex  = hits(i_ex_instr, i_rf_instr.src_a, i_rf_instr.use_a)
                || hits(i_ex_instr, i_rf_instr.src_b, i_rf_instr.use_b);
      // Producer ahead of a dependent instruction is still loading
      ld_ilk_c = rf_live && i_ex_instr.is_load && dep_ex && !st_reg.bubble;
      md_ilk_c = rf_live && i_rf_instr.is_mfprod && i_muldiv_busy;
      stld_ilk_c = rf_live && ex_live && i_ex_instr.is_store && i_rf_instr.is_load
                   && !st_reg.stld_ilk;
      cpi_c = rf_live && ex_live && i_ex_instr.is_cop_cfg && !st_reg.cpi;
      dcb_c = rf_live && i_rf_instr.is_mem && st_reg.store_busy && !st_reg.hold;
      // Run only if nothing blocks; otherwise re-evaluated next cycle
      slip_c = ld_ilk_c || md_ilk_c || stld_ilk_c || cpi_c || dcb_c;

      st_next.ld_ilk   = ld_ilk_c;
      st_next.md_ilk   = md_ilk_c;
      st_next.stld_ilk = stld_ilk_c;
      st_next.cpi    = cpi_c;
      st_next.hold   = slip_c;
      st_next.bubble = slip_c;
      // Second cache cycle of a store entering the data cache stage
      st_next.store_busy = ex_live && i_ex_instr.is_store && !st_reg.bubble;

      unique case (st_reg.state)
         psb_pkg::PSB_RUN: begin
            if (ld_ilk_c) begin
               st_next.state = psb_pkg::PSB_SLIP_LD;
            end else if (md_ilk_c) begin
               st_next.state = psb_pkg::PSB_SLIP_MD;
            end else if (slip_c) begin
               st_next.state = psb_pkg::PSB_SLIP_ONE;
            end
         end
         // Awaited value now at end of data cache stage
         psb_pkg::PSB_SLIP_LD: begin
            st_next.state = slip_c ? psb_pkg::PSB_SLIP_ONE : psb_pkg::PSB_RUN;
         end
         psb_pkg::PSB_SLIP_MD: begin
            st_next.state = md_ilk_c ? psb_pkg::PSB_SLIP_MD : psb_pkg::PSB_RUN;
         end
         psb_pkg::PSB_SLIP_ONE: begin
            st_next.state = slip_c ? psb_pkg::PSB_SLIP_ONE : psb_pkg::PSB_RUN;
         end
      endcase

      // Value arriving from data cache stage enters register fetch latch
      st_next.dc_to_rf_a = (ld_ilk_c || md_ilk_c || st_reg.ld_ilk)
                           && hits(i_dc_instr, i_rf_instr.src_a, i_rf_instr.use_a);
      st_next.dc_to_rf_b = (ld_ilk_c || md_ilk_c || st_reg.ld_ilk)
                           && hits(i_dc_instr, i_rf_instr.src_b, i_rf_instr.use_b);
      // Resume cycle: awaited load now sits in data cache stage, or muldiv product is ready for a move-from product
      if (!slip_c && (st_reg.ld_ilk || st_reg.md_ilk)) begin
         st_next.dc_to_rf_a = hits(i_dc_instr, i_rf_instr.src_a, i_rf_instr.use_a)
                              || (st_reg.md_ilk && i_rf_instr.is_mfprod && i_rf_instr.use_a);
         st_next.dc_to_rf_b = hits(i_dc_instr, i_rf_instr.src_b, i_rf_instr.use_b);
      end

      // Selects for the instruction entering execute; register file during a slip
      if (slip_c) begin
         st_next.sel_a = psb_pkg::PSB_SEL_RF;
         st_next.sel_b = psb_pkg::PSB_SEL_RF;
      end else begin
         st_next.sel_a = pick(i_ex_instr, i_dc_instr, i_wb_instr,
                              i_rf_instr.src_a, i_rf_instr.use_a);
         st_next.sel_b = pick(i_ex_instr, i_dc_instr, i_wb_instr,
                              i_rf_instr.src_b, i_rf_instr.use_b);
      end

      st_next.rf_ra = i_rf_instr.src_a;
      st_next.rf_rb = i_rf_instr.src_b;
      st_next.rf_wa = i_dc_instr.dest;
      st_next.rf_we = i_dc_instr.valid && !i_dc_instr.killed && i_dc_instr.wr_dest
                      && (i_dc_instr.dest != `PSB_ZERO_REG);
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      o_fetch_hold  = st_reg.hold;
      o_ex_bubble   = st_reg.bubble;
      o_ld_ilk      = st_reg.ld_ilk;
      o_md_ilk      = st_reg.md_ilk;
      o_stld_ilk    = st_reg.stld_ilk;
      o_cpi         = st_reg.cpi;
      o_ex_sel_a    = st_reg.sel_a;
      o_ex_sel_b    = st_reg.sel_b;
      o_rf_dc_byp_a = st_reg.dc_to_rf_a;
      o_rf_dc_byp_b = st_reg.dc_to_rf_b;
      o_rf_read_a   = st_reg.rf_ra;
      o_rf_read_b   = st_reg.rf_rb;
      o_rf_write_a  = st_reg.rf_wa;
      o_rf_write_en = st_reg.rf_we;
   end

endmodule

// ---- testbench/psb_pipeline_slip_bypass_control_props.sv ----
`timescale 1ns/1ps
module psb_pipeline_slip_bypass_control_props (
   input wire logic                i_ref_clk,     // Clock
   input wire logic                i_reset_n,     // Reset
   input wire psb_pkg::psb_instr_s i_rf_instr,    // Reg fetch
   input wire psb_pkg::psb_instr_s i_ex_instr,    // Execute
   input wire logic                i_muldiv_busy, // Muldiv
   input wire logic                o_fetch_hold,  // Hold
   input wire logic                o_ex_bubble,   // Bubble
   input wire logic                o_ld_ilk,      // Load slip
   input wire logic                o_md_ilk,      // Muldiv slip
   input wire logic                o_stld_ilk,    // Store-load slip
   input wire logic                o_cpi,         // Coproc slip
   input wire logic                o_rf_dc_byp_a, // Bypass A
   input wire logic                o_rf_dc_byp_b, // Bypass B
   input wire psb_pkg::psb_reg_t   o_rf_read_a,   // Read addr A
   input wire psb_pkg::psb_reg_t   o_rf_write_a,  // Write addr
   input wire logic                o_rf_write_en  // Write enable
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   logic ld_haz;
   logic md_haz;
   // Load in execute feeding operand A of the next instruction
   assign ld_haz = i_ex_instr.valid && !i_ex_instr.killed && i_ex_instr.is_load && i_ex_instr.wr_dest
                   && (i_ex_instr.dest != 5'h00) && i_rf_instr.valid && !i_rf_instr.killed
                   && i_rf_instr.use_a && (i_rf_instr.src_a == i_ex_instr.dest) && !o_ex_bubble;
   assign md_haz = i_rf_instr.valid && !i_rf_instr.killed && i_rf_instr.is_mfprod && i_muldiv_busy;
   chk_bubble_with_hold: assert property (o_ex_bubble == o_fetch_hold) else $error("bubble differs from hold");
   chk_killed_no_slip: assert property (i_rf_instr.killed |=> !o_fetch_hold) else $error("killed slipped");
   chk_load_slip: assert property (ld_haz |=> o_ld_ilk && o_fetch_hold) else $error("load slip missing");
   chk_load_resume: assert property (o_ld_ilk |=> !o_ld_ilk) else $error("load slip repeated");
   chk_load_bypass: assert property (o_ld_ilk |=> o_rf_dc_byp_a || o_rf_dc_byp_b) else $error("no bypass");
   chk_muldiv_slip: assert property (md_haz |=> o_md_ilk && o_fetch_hold) else $error("muldiv slip missing");
   chk_muldiv_resume: assert property (o_md_ilk && !i_muldiv_busy |=> !o_md_ilk && o_rf_dc_byp_a)
      else $error("muldiv resume wrong");
   chk_store_load_once: assert property (o_stld_ilk |-> o_fetch_hold ##1 !o_stld_ilk)
      else $error("store-load slip wrong");
   chk_coproc_once: assert property (o_cpi |-> o_fetch_hold ##1 !o_cpi) else $error("coproc slip wrong");
   chk_read_addr: assert property ($past(i_reset_n) |-> o_rf_read_a == $past(i_rf_instr.src_a))
      else $error("read address wrong");
   chk_zero_write: assert property (o_rf_write_en |-> o_rf_write_a != 5'h00) else $error("reg zero written");
endmodule
bind psb_pipeline_slip_bypass_control psb_pipeline_slip_bypass_control_props u_props (.i_ref_clk(i_ref_clk),
   .i_reset_n(i_reset_n), .i_rf_instr(i_rf_instr), .i_ex_instr(i_ex_instr), .i_muldiv_busy(i_muldiv_busy),
   .o_fetch_hold(o_fetch_hold), .o_ex_bubble(o_ex_bubble), .o_ld_ilk(o_ld_ilk), .o_md_ilk(o_md_ilk),
   .o_stld_ilk(o_stld_ilk),
   .o_cpi(o_cpi), .o_rf_dc_byp_a(o_rf_dc_byp_a), .o_rf_dc_byp_b(o_rf_dc_byp_b), .o_rf_read_a(o_rf_read_a),
   .o_rf_write_a(o_rf_write_a), .o_rf_write_en(o_rf_write_en));

// ---- testbench/psb_pipeline_slip_bypass_control_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module psb_pipeline_slip_bypass_control_test;
   logic                clk = 1'b0;
   logic                reset_n = 1'b0;
   logic                busy = 1'b0;
   psb_pkg::psb_instr_s rf = '0, ex = '0, dc = '0, wb = '0;
   logic                hold, bub, ld_ilk, md_ilk, stld_ilk, cpi, byp_a, byp_b, wr_en;
   psb_pkg::psb_sel_e   sel_a, sel_b;
   psb_pkg::psb_reg_t   rd_a, rd_b, wr_a;
   int                  n_mismatch = 0;
   int                  checked = 0;
   localparam logic [4:0] LD = 5'h14, ST = 5'h0C, MF = 5'h02, CP = 5'h01;
   always #5 clk = ~clk;
   psb_pipeline_slip_bypass_control DUT (.i_ref_clk(clk), .i_reset_n(reset_n), .i_rf_instr(rf),
      .i_ex_instr(ex), .i_dc_instr(dc), .i_wb_instr(wb), .i_muldiv_busy(busy), .o_fetch_hold(hold),
      .o_ex_bubble(bub), .o_ld_ilk(ld_ilk), .o_md_ilk(md_ilk), .o_stld_ilk(stld_ilk), .o_cpi(cpi),
      .o_ex_sel_a(sel_a),
      .o_ex_sel_b(sel_b), .o_rf_dc_byp_a(byp_a), .o_rf_dc_byp_b(byp_b), .o_rf_read_a(rd_a),
      .o_rf_read_b(rd_b), .o_rf_write_a(wr_a), .o_rf_write_en(wr_en));
   function automatic psb_pkg::psb_instr_s ins(input logic [4:0] a, input logic [4:0] b,
                                               input logic [4:0] d, input logic [4:0] f);
      ins = '0;
      ins.valid = 1'b1;
      ins.src_a = a;
      ins.src_b = b;
      ins.use_a = 1'b1;
      ins.use_b = 1'b1;
      ins.dest = d;
      ins.wr_dest = (d != 5'h00);
      {ins.is_load, ins.is_store, ins.is_mem, ins.is_mfprod, ins.is_cop_cfg} = f;
   endfunction
   task cyc; @(negedge clk); endtask
   task clr;
      {rf, ex, dc, wb} = '0;
      busy = 1'b0;
      repeat (2) cyc;
   endtask
   task t_load_use;
      clr;
      ex = ins(5'h01, 5'h02, 5'h03, LD);
      rf = ins(5'h03, 5'h04, 5'h06, 5'h00);
      cyc;
      `CHK("hold", 1'b1, hold)
      `CHK("ld_ilk", 1'b1, ld_ilk)
      `CHK("bubble", 1'b1, bub)
      dc = ex;
      ex = '0;
      cyc;
      `CHK("hold", 1'b0, hold)
      `CHK("byp_a", 1'b1, byp_a)
      `CHK("rd_a", 5'h03, rd_a)
      `CHK("wr_en", 1'b1, wr_en)
      `CHK("wr_a", 5'h03, wr_a)
   endtask
   task t_killed;
      clr;
      ex = ins(5'h01, 5'h02, 5'h03, LD);
      rf = ins(5'h03, 5'h04, 5'h06, 5'h00);
      rf.killed = 1'b1;
      cyc;
      `CHK("hold", 1'b0, hold)
      `CHK("ld_ilk", 1'b0, ld_ilk)
   endtask
   task t_muldiv;
      clr;
      rf = ins(5'h00, 5'h00, 5'h08, MF);
      busy = 1'b1;
      repeat (3) begin
         cyc;
         `CHK("hold", 1'b1, hold)
         `CHK("md_ilk", 1'b1, md_ilk)
      end
      busy = 1'b0;
      cyc;
      `CHK("hold", 1'b0, hold)
      `CHK("byp_a", 1'b1, byp_a)
   endtask
   task t_one_clk(input logic [4:0] exf, input logic [4:0] rff, input logic is_sl);
      clr;
      ex = ins(5'h01, 5'h00, 5'h00, exf);
      rf = ins(5'h02, 5'h03, 5'h09, rff);
      cyc;
      `CHK("hold", 1'b1, hold)
      `CHK("stld_ilk", is_sl, stld_ilk)
      `CHK("cpi", !is_sl, cpi)
      dc = ex;
      ex = '0;
      cyc;
      `CHK("hold", 1'b0, hold)
   endtask
   task t_cache_busy;
      clr;
      ex = ins(5'h01, 5'h00, 5'h00, ST);
      rf = ins(5'h02, 5'h03, 5'h04, 5'h00);
      cyc;
      `CHK("hold", 1'b0, hold)
      dc = ex;
      ex = rf;
      rf = ins(5'h05, 5'h00, 5'h06, LD);
      cyc;
      `CHK("hold", 1'b1, hold)
      wb = dc;
      dc = ex;
      ex = '0;
      cyc;
      `CHK("hold", 1'b0, hold)
   endtask
   task t_forward;
      clr;
      ex = ins(5'h01, 5'h00, 5'h05, 5'h00);
      dc = ins(5'h01, 5'h00, 5'h06, 5'h00);
      wb = ins(5'h01, 5'h00, 5'h06, 5'h00);
      rf = ins(5'h05, 5'h06, 5'h07, 5'h00);
      cyc;
      `CHK("sel_a", psb_pkg::PSB_SEL_EX, sel_a)
      `CHK("sel_b", psb_pkg::PSB_SEL_DC, sel_b)
      ex = '0;
      dc = '0;
      rf = ins(5'h06, 5'h00, 5'h07, 5'h00);
      cyc;
      `CHK("sel_a", psb_pkg::PSB_SEL_WB, sel_a)
      `CHK("sel_b", psb_pkg::PSB_SEL_RF, sel_b)
   endtask
   task end_sim;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      end_sim;
   end
   initial begin
      repeat (8) cyc;
      reset_n = 1'b1;
      t_load_use;
      t_killed;
      t_muldiv;
      t_one_clk(ST, LD, 1'b1);
      t_one_clk(CP, 5'h00, 1'b0);
      t_cache_busy;
      t_forward;
      end_sim;
   end
endmodule
